/* File: inc/sblb_regs.vh */
/*
 constants for the boolean logic stage: block type codes, input
 count limits, scan timing and sequencer states.
 assumes inclusion by bare name from the design files.
*/
`ifndef SBLB_REGS_VH
`define SBLB_REGS_VH

// ****************************************************************
// block type codes
// ****************************************************************
`define SBLB_T_AND   3'h0
`define SBLB_T_OR    3'h1
`define SBLB_T_NAND  3'h2
`define SBLB_T_NOR   3'h3
`define SBLB_T_XOR   3'h4
`define SBLB_T_NOT   3'h5
`define SBLB_T_RSFF  3'h6
`define SBLB_T_SRFF  3'h7

// ****************************************************************
// input count limits and input positions
// ****************************************************************
`define SBLB_CNT_MIN  3'h2
`define SBLB_CNT_MAX  3'h5
`define SBLB_CNT_ONE  3'h1
`define SBLB_IN_SET   0
`define SBLB_IN_RST   1
`define SBLB_POP_ONE  3'h1
`define SBLB_SI_BASE  0

// ****************************************************************
// scan timing, in ns
// ****************************************************************
`define SBLB_CLK_NS   8
`define SBLB_SCAN_NS  1000

// ****************************************************************
// sequencer states and reset values
// ****************************************************************
`define SBLB_ST_SAMPLE  2'h0
`define SBLB_ST_EVAL    2'h1
`define SBLB_ST_COMMIT  2'h2
`define SBLB_RST_BIT    1'h0

`endif

/* File: verilog/sblb_gate.v */
/*
 one configurable logic block: and, or, nand, nor, xor, not and
 the two flip-flop kinds. purely combinational next value.
 assumes inputs already carry any per-input inversion and that the
 caller holds the stored flip-flop value and applies output invert.
*/
`timescale 1ns/1ps
`include "sblb_regs.vh"

module sblb_gate (
   input  wire [2:0] type_i,
   input  wire [2:0] count_i,
   input  wire [4:0] in_i,
   input  wire       state_i,
   output reg        result_o,
   output wire       cnt_err_o
);

   wire [2:0] cnt_eff;
   wire [4:0] en;
   wire       and_v;
   wire       or_v;
   reg  [2:0] pop;
   integer    k;

   // ****************************************************************
   // input count handling
   // ****************************************************************
   // out-of-range counts are clamped rather than refused, flagged
   assign cnt_err_o = (type_i != `SBLB_T_NOT) &&
                      ((count_i < `SBLB_CNT_MIN) ||
                       (count_i > `SBLB_CNT_MAX));
   assign cnt_eff = (type_i == `SBLB_T_NOT)   ? `SBLB_CNT_ONE :
                    (count_i < `SBLB_CNT_MIN) ? `SBLB_CNT_MIN :
                    (count_i > `SBLB_CNT_MAX) ? `SBLB_CNT_MAX :
                    count_i;

   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1) begin : g_en
         assign en[g] = (g < cnt_eff);
      end
   endgenerate

   // ****************************************************************
   // reductions
   // ****************************************************************
   // unused inputs are don't-care
   assign and_v = &(in_i | ~en);
   assign or_v  = |(in_i & en);

   always @* begin
      pop = 3'h0;
      for (k = 0; k < 5; k = k + 1) begin
         pop = pop + {2'h0, in_i[k] & en[k]};
      end
   end

   // ****************************************************************
   // function select
   // ****************************************************************
   always @* begin
      case (type_i)
         `SBLB_T_AND:  result_o = and_v;
         `SBLB_T_OR:   result_o = or_v;
         `SBLB_T_NAND: result_o = ~and_v;
         `SBLB_T_NOR:  result_o = ~or_v;
         `SBLB_T_XOR:  result_o = (pop == `SBLB_POP_ONE);
         `SBLB_T_NOT:  result_o = ~in_i[0];
         `SBLB_T_RSFF: result_o = ~in_i[`SBLB_IN_RST] &
                                  (in_i[`SBLB_IN_SET] | state_i);
         `SBLB_T_SRFF: result_o = in_i[`SBLB_IN_SET] |
                                  (~in_i[`SBLB_IN_RST] & state_i);
         default:      result_o = 1'b0;
      endcase
   end

endmodule

/* File: verilog/sblb_logic_top.v */
/*
 boolean logic stage of a safety controller: a bank of configurable
 logic blocks evaluated once per scan, sources drawn from safety
 inputs, non-safety inputs, safety output feedback and block outputs.
 assumes pin inputs are asynchronous to clk_i and configuration
 ports are static, driven from logic on clk_i.
*/
`timescale 1ns/1ps
`include "sblb_regs.vh"

module sblb_logic_top #(
   parameter NSI     = 8,
   parameter NNS     = 8,
   parameter NSO     = 4,
   parameter NBLK    = 8,
   parameter SELW    = 5,
   parameter SCAN_NS = `SBLB_SCAN_NS
) (
   input  wire                  clk_i,
   input  wire                  reset_i,
   input  wire [NSI-1:0]        safety_in_i,
   input  wire [NNS-1:0]        nonsafe_in_i,
   input  wire [NSO-1:0]        sout_fb_i,
   input  wire [NBLK*3-1:0]     blk_type_i,
   input  wire [NBLK*3-1:0]     blk_count_i,
   input  wire [NBLK*5*SELW-1:0] blk_sel_i,
   input  wire [NBLK*5-1:0]     blk_inv_in_i,
   input  wire [NBLK-1:0]       blk_inv_out_i,
   output wire [NBLK-1:0]       blk_out_o,
   output wire                  scan_done_o,
   output wire                  scan_busy_o,
   output wire [NBLK-1:0]       cfg_err_o
);

   // ****************************************************************
   // derived sizes and timing
   // ****************************************************************
   localparam NSRC = NSI + NNS + NSO + NBLK;
   // least scan time, rounded up to whole cycles
   localparam SCAN_CYC =
      (SCAN_NS + `SBLB_CLK_NS - 1) / `SBLB_CLK_NS;
   localparam CW = 16;
   localparam integer  LAST_INT = SCAN_CYC - 1;
   localparam [CW-1:0] LAST_CYC = LAST_INT[CW-1:0];
   localparam [1:0] ST_SAMPLE = `SBLB_ST_SAMPLE;
   localparam [1:0] ST_EVAL   = `SBLB_ST_EVAL;
   localparam [1:0] ST_COMMIT = `SBLB_ST_COMMIT;
   // source map bases, in snapshot index order
   localparam SI_BASE = `SBLB_SI_BASE;
   localparam NS_BASE = SI_BASE + NSI;
   localparam SO_BASE = NS_BASE + NNS;
   localparam BK_BASE = SO_BASE + NSO;

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg  [NSI-1:0]  si_meta_r;
   reg  [NSI-1:0]  si_sync_r;
   reg  [NNS-1:0]  ns_meta_r;
   reg  [NNS-1:0]  ns_sync_r;
   reg  [NSO-1:0]  so_meta_r;
   reg  [NSO-1:0]  so_sync_r;
   reg  [NSRC-1:0] snap_r;
   reg  [NSRC-1:0] snap_nxt;
   reg  [NBLK-1:0] state_r;
   reg  [NBLK-1:0] state_nxt;
   reg  [NBLK-1:0] out_r;
   reg  [NBLK-1:0] out_nxt;
   reg  [NBLK-1:0] err_r;
   reg  [NBLK-1:0] err_nxt;
   reg  [1:0]      st_r;
   reg  [1:0]      st_nxt;
   reg  [CW-1:0]   cnt_r;
   reg  [CW-1:0]   cnt_nxt;
   reg             done_r;
   reg             done_nxt;
   wire [NBLK-1:0] result;
   wire [NBLK-1:0] cnt_err;
   wire [NBLK-1:0] sel_err;
   wire [NBLK-1:0] cfg_bad;
   wire [NSRC-1:0] src_now;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // pins are asynchronous; only the second stage is read
   always @(posedge clk_i) begin
      if (reset_i) begin
         si_meta_r <= {NSI{`SBLB_RST_BIT}};
         si_sync_r <= {NSI{`SBLB_RST_BIT}};
      end else begin
         si_meta_r <= safety_in_i;
         si_sync_r <= si_meta_r;
      end
   end

   // non-safety pins take the same two stages as safety pins
   always @(posedge clk_i) begin
      if (reset_i) begin
         ns_meta_r <= {NNS{`SBLB_RST_BIT}};
         ns_sync_r <= {NNS{`SBLB_RST_BIT}};
      end else begin
         ns_meta_r <= nonsafe_in_i;
         ns_sync_r <= ns_meta_r;
      end
   end

   // output feedback comes back from the pins, so it is a pin too;
   // two stages add latency, which a whole scan hides anyway
   always @(posedge clk_i) begin
      if (reset_i) begin
         so_meta_r <= {NSO{`SBLB_RST_BIT}};
         so_sync_r <= {NSO{`SBLB_RST_BIT}};
      end else begin
         so_meta_r <= sout_fb_i;
         so_sync_r <= so_meta_r;
      end
   end

   // ****************************************************************
   // scan sequencer
   // ****************************************************************
   // one evaluation per scan
   always @* begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      case (st_r)
         ST_SAMPLE: begin
            cnt_nxt = {CW{1'b0}};
            st_nxt  = ST_EVAL;
         end
         ST_EVAL: begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r >= LAST_CYC) begin
               st_nxt = ST_COMMIT;
            end
         end
         ST_COMMIT: begin
            st_nxt   = ST_SAMPLE;
         end
         default: begin
            st_nxt = ST_SAMPLE;
         end
      endcase
   end

   // ****************************************************************
   // scan done pulse
   // ****************************************************************
   // registered, so it rises with the committed outputs, not before
   always @* begin
      done_nxt = (st_r == ST_COMMIT);
   end

   // ****************************************************************
   // source map
   // ****************************************************************
   // pins, feedback and blocks share one index space
   assign src_now[SI_BASE +: NSI]  = si_sync_r;
   assign src_now[NS_BASE +: NNS]  = ns_sync_r;
   assign src_now[SO_BASE +: NSO]  = so_sync_r;
   // block sources are last scan's outputs, so a chain of n blocks
   // needs n scans to settle; no loop can oscillate inside a scan
   assign src_now[BK_BASE +: NBLK] = out_r;

   // ****************************************************************
   // source snapshot
   // ****************************************************************
   // one source vector for all inputs
   // sampling once per scan keeps every block on one consistent
   // picture; block outputs are those of the previous scan
   always @* begin
      snap_nxt = snap_r;
      if (st_r == ST_SAMPLE) begin
         snap_nxt = src_now;
      end
   end

   // ****************************************************************
   // block bank
   // ****************************************************************
   genvar b;
   genvar k;
   generate
      for (b = 0; b < NBLK; b = b + 1) begin : g_blk
         wire [4:0] raw;
         wire [4:0] bad;
         wire [4:0] gin;
         wire [2:0] blk_typ;
         wire [2:0] blk_cnt;
         wire [4:0] blk_inv;
         // per-block slices of the flat configuration ports
         assign blk_typ = blk_type_i[b*3 +: 3];
         assign blk_cnt = blk_count_i[b*3 +: 3];
         assign blk_inv = blk_inv_in_i[b*5 +: 5];
         for (k = 0; k < 5; k = k + 1) begin : g_in
            wire [SELW-1:0] sel;
            assign sel = blk_sel_i[(b*5+k)*SELW +: SELW];
            // any source by index
            // an unmapped index reads off, the safe state
            assign bad[k] = (sel >= NSRC);
            assign raw[k] = bad[k] ? 1'b0 : snap_r[sel];
         end
         assign gin = raw ^ blk_inv;
         assign sel_err[b] = |bad;
         sblb_gate u_gate (
            .type_i    (blk_typ),
            .count_i   (blk_cnt),
            .in_i      (gin),
            .state_i   (state_r[b]),
            .result_o  (result[b]),
            .cnt_err_o (cnt_err[b])
         );
      end
   endgenerate

   // ****************************************************************
   // configuration errors
   // ****************************************************************
   // bad counts and indices are flagged, never refused: the stage
   // keeps scanning on the safe reading while software sees the flag
   assign cfg_bad = cnt_err | sel_err;

   // ****************************************************************
   // commit at scan end
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      out_nxt   = out_r;
      err_nxt   = err_r;
      if (st_r == ST_COMMIT) begin
         state_nxt = result;
         out_nxt   = result ^ blk_inv_out_i;
         err_nxt   = cfg_bad;
      end
   end

   // ****************************************************************
   // sequencer registers
   // ****************************************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         st_r   <= ST_SAMPLE;
         cnt_r  <= {CW{1'b0}};
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   // ****************************************************************
   // snapshot register
   // ****************************************************************
   // cleared too, so no picture from before a reset is evaluated
   always @(posedge clk_i) begin
      if (reset_i) begin
         snap_r <= {NSRC{`SBLB_RST_BIT}};
      end else begin
         snap_r <= snap_nxt;
      end
   end

   // ****************************************************************
   // block registers
   // ****************************************************************
   always @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= {NBLK{`SBLB_RST_BIT}};
         out_r   <= {NBLK{`SBLB_RST_BIT}};
         err_r   <= {NBLK{1'b0}};
      end else begin
         state_r <= state_nxt;
         out_r   <= out_nxt;
         err_r   <= err_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // binary block results
   assign blk_out_o   = out_r;
   assign scan_done_o = done_r;
   assign scan_busy_o = (st_r != ST_SAMPLE);
   assign cfg_err_o   = err_r;

endmodule

/* File: bench/sblb_chk.sv */
/* checker: scan pacing, output hold and count overflow flag of the stage.
   assumes only the top ports are visible. */
`timescale 1ns/1ps
module sblb_chk #(
   parameter NBLK    = 8,
   parameter SCAN_NS = 1000
) (
   input wire            clk_i,
   input wire            reset_i,
   input wire [NBLK*3-1:0] blk_type_i,
   input wire [NBLK*3-1:0] blk_count_i,
   input wire [NBLK-1:0] blk_out_o,
   input wire            scan_done_o,
   input wire            scan_busy_o,
   input wire [NBLK-1:0] cfg_err_o
);
   // ****
   // scan checks
   // ****
   // one sample, SCAN_CYC evaluate and one commit cycle per scan
   localparam int P  = (SCAN_NS + 7) / 8 + 2;
   localparam int PB = P - 1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   AST_DONE_PULSE: assert property (scan_done_o |=> !scan_done_o)
      else $error("scan done longer than one cycle");
   AST_SCAN_PERIOD: assert property (scan_done_o |-> ##P scan_done_o)
      else $error("scan period wrong");
   AST_OUT_HOLD: assert property ($changed(blk_out_o) |-> scan_done_o)
      else $error("block outputs moved mid scan");
   AST_ERR_HOLD: assert property ($changed(cfg_err_o) |-> scan_done_o)
      else $error("config error moved mid scan");
   AST_DONE_IN_SAMPLE: assert property (scan_done_o |-> !scan_busy_o)
      else $error("busy during scan done");
   AST_SAMPLE_ONE: assert property (!scan_busy_o |=> scan_busy_o)
      else $error("sample longer than one cycle");
   AST_BUSY_LEN: assert property ($rose(scan_busy_o) |->
      ##PB $fell(scan_busy_o))
      else $error("busy length wrong");
   // too many inputs is clamped but flagged
   AST_CFG_ERR: assert property (scan_done_o &&
      blk_type_i[2:0] < 3'h5 && blk_count_i[2:0] > 3'h5 |-> cfg_err_o[0])
      else $error("count overflow not flagged");
endmodule
bind sblb_logic_top sblb_chk #(.NBLK(NBLK), .SCAN_NS(SCAN_NS)) i_chk (
   .clk_i(clk_i), .reset_i(reset_i), .blk_type_i(blk_type_i),
   .blk_count_i(blk_count_i), .blk_out_o(blk_out_o),
   .scan_done_o(scan_done_o), .scan_busy_o(scan_busy_o),
   .cfg_err_o(cfg_err_o));

/* File: bench/sblb_src_model.sv */
/* input devices and output feedback seen by the logic stage.
   assumes a free running clk_i; all levels change on its edge. */
`timescale 1ns/1ps
module sblb_src_model (
   input  wire       clk_i,
   input  wire [4:0] pat_i,
   output reg  [7:0] safety_o = 8'h00,
   output reg  [7:0] nonsafe_o = 8'h00,
   output reg  [3:0] sout_o = 4'h0
);
   always @(posedge clk_i) begin
      safety_o  <= {3'h5, pat_i};
      nonsafe_o <= {3'h2, ~pat_i};
      sout_o    <= pat_i[3:0] ^ 4'hA;
   end
endmodule

/* File: bench/test_sblb_logic_top.sv */
/* bench: one block of each kind, swept over all input patterns.
   assumes the short scan, so four scans settle any pattern. */
`timescale 1ns/1ps
module test_sblb_logic_top;
   // ****
   // stimulus and model
   // ****
   reg          clk_i = 1'b0;
   reg          reset_i = 1'b1;
   reg  [4:0]   pat = 5'h00;
   reg  [23:0]  typ = 24'hFAC688;
   reg  [23:0]  cnt = 24'h495757;
   reg  [199:0] sel;
   reg  [39:0]  inv = 40'h0000000801;
   reg  [7:0]   iout = 8'h90;
   reg  [7:0]   eerr = 8'h01;
   reg  [7:0]   st, exp;
   integer      failures, checks, i;
   wire [7:0]   si, ns, out, err;
   wire [3:0]   fb;
   wire         done;
   sblb_src_model i_src (.clk_i(clk_i), .pat_i(pat), .safety_o(si),
      .nonsafe_o(ns), .sout_o(fb));
   sblb_logic_top #(.SCAN_NS(16)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
      .safety_in_i(si), .nonsafe_in_i(ns), .sout_fb_i(fb),
      .blk_type_i(typ), .blk_count_i(cnt), .blk_sel_i(sel),
      .blk_inv_in_i(inv), .blk_inv_out_i(iout), .blk_out_o(out),
      .scan_done_o(done), .scan_busy_o(), .cfg_err_o(err));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   function ev(input [2:0] t, input [2:0] c, input [4:0] v, input s);
      integer k;
      reg [2:0] n;
      reg a, o;
      begin
         n = 3'h0; a = 1'b1; o = 1'b0;
         for (k = 0; k < c; k = k + 1) begin
            a = a & v[k]; o = o | v[k]; n = n + {2'h0, v[k]};
         end
         case (t)
            3'h0: ev = a;
            3'h1: ev = o;
            3'h2: ev = !a;
            3'h3: ev = !o;
            3'h4: ev = (n == 3'h1);
            3'h5: ev = !v[0];
            3'h6: ev = v[1] ? 1'b0 : (v[0] | s);
            default: ev = v[0] | (!v[1] & s);
         endcase
      end
   endfunction
   task chk(input [7:0] got, input [7:0] want);
      begin
         checks = checks + 1;
         if (got !== want) begin
            failures = failures + 1;
            $display("unexpected at %0t: %h vs %h", $time, got, want);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wait_done;
      integer n;
      begin
         n = 0;
         @(negedge clk_i);
         while (done !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n = n + 1;
         end
         if (done !== 1'b1) begin
            failures = failures + 1;
            final_report;
         end
      end
   endtask
   task settle(input [4:0] p);
      integer b, k;
      reg [27:0] src;
      reg [4:0]  v;
      reg [2:0]  c;
      reg [4:0]  s;
      begin
         @(posedge clk_i);
         pat <= p;
         repeat (4) wait_done;
         for (b = 0; b < 8; b = b + 1) begin
            src = {exp, p[3:0] ^ 4'hA, 3'h2, ~p, 3'h5, p};
            for (k = 0; k < 5; k = k + 1) begin
               s = sel[(b*5+k)*5+:5];
               v[k] = ((s < 5'h1C) ? src[s] : 1'b0) ^ inv[b*5+k];
            end
            c = (cnt[b*3+:3] > 3'h5) ? 3'h5 : cnt[b*3+:3];
            if (c < 3'h2)
               c = 3'h2;
            st[b] = ev(typ[b*3+:3], c, v, st[b]);
            exp[b] = st[b] ^ iout[b];
         end
         chk(out, exp);
         chk(err, eerr);
      end
   endtask
   task do_reset;
      begin
         @(posedge clk_i);
         reset_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         reset_i <= 1'b0;
         st = 8'h00;
         exp = 8'h00;
         @(negedge clk_i);
         chk(out | err, 8'h00);
      end
   endtask
   // stride 7 visits set then hold for both the RS and the SR flip-flop
   task sweep;
      reg [4:0] q;
      begin
         q = 5'h00;
         for (i = 0; i < 32; i = i + 1) begin
            settle(q);
            q = q + 5'h07;
         end
      end
   endtask
   // an unmapped index reads off; a count below two clamps to two
   task bad_index;
      begin
         @(posedge clk_i);
         sel[85+:5] <= 5'h1F;
         cnt[12+:3] <= 3'h1;
         eerr = 8'h19;
         settle(5'h01);
         @(posedge clk_i);
         sel[85+:5] <= 5'h00;
         cnt[12+:3] <= 3'h5;
         eerr = 8'h01;
      end
   endtask
   task ff_clear;
      begin
         settle(5'h02);
         do_reset;
         settle(5'h00);
      end
   endtask
   initial begin
      failures = 0;
      checks = 0;
      for (i = 0; i < 40; i = i + 1)
         sel[i*5+:5] = (i % 5 + i / 5) % 5;
      sel[30+:5] = 5'h08;
      sel[120+:5] = 5'h10;
      sel[125+:5] = 5'h14;
      do_reset;
      sweep;
      bad_index;
      ff_clear;
      final_report;
   end
endmodule
